// ### sync_serial_pkg.sv
// constants shared by the sync serial clocking and shift core
package sync_serial_pkg;

   // register byte addresses
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CLOCK_MODE_OFS = 8'h04;
   localparam logic [7:0] RX_CLOCK_MODE_OFS = 8'h10;
   localparam logic [7:0] RX_FRAME_OFS = 8'h14;
   localparam logic [7:0] TX_CLOCK_MODE_OFS = 8'h18;
   localparam logic [7:0] TX_FRAME_OFS = 8'h1c;
   localparam logic [7:0] RX_HOLD_OFS = 8'h20;
   localparam logic [7:0] TX_HOLD_OFS = 8'h24;
   localparam logic [7:0] STATUS_OFS = 8'h40;
   localparam logic [7:0] INT_ENABLE_OFS = 8'h44;
   localparam logic [7:0] INT_DISABLE_OFS = 8'h48;
   localparam logic [7:0] INT_MASK_OFS = 8'h4c;

   // control register bits
   localparam int RX_EN_BIT = 0;
   localparam int TX_EN_BIT = 1;

   // clock mode register fields (transmit and receive alike)
   localparam int CKS_LSB = 0;
   localparam int CKO_LSB = 2;
   localparam int CKI_BIT = 5;
   localparam int START_LSB = 8;
   localparam int RATIO_W = 12;

   // frame register fields
   localparam int DATLEN_LSB = 0;
   localparam int MSBF_BIT = 7;

   // status bits
   localparam int TX_FREE_BIT = 0;
   localparam int TX_DRAINED_BIT = 1;
   localparam int RX_AVAIL_BIT = 4;
   localparam int OVERRUN_BIT = 5;
   localparam int STATUS_W = 6;

   // clock source select codes
   localparam logic [1:0] CKS_PIN = 2'h0;
   localparam logic [1:0] CKS_OTHER = 2'h1;
   localparam logic [1:0] CKS_DIV = 2'h2;

   // clock output mode codes
   localparam logic [1:0] CKO_NONE = 2'h0;
   localparam logic [1:0] CKO_CONT = 2'h1;
   localparam logic [1:0] CKO_XFER = 2'h2;

   // start event codes
   localparam logic [2:0] START_CONT = 3'h0;
   localparam logic [2:0] START_OTHER = 3'h1;
   localparam logic [2:0] START_LOW = 3'h2;
   localparam logic [2:0] START_HIGH = 3'h3;
   localparam logic [2:0] START_FALL = 3'h4;
   localparam logic [2:0] START_RISE = 3'h5;
   localparam logic [2:0] START_ANY = 3'h6;

   // reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   typedef enum logic {IDLE, SHIFT} path_state_t;

endpackage

// ### sync_serial_unit.sv
// sync serial unit: clock divider, clock selection and shift paths
`timescale 1ns/1ps
module sync_serial_unit import sync_serial_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic tx_clock_in,
   output logic tx_clock_out,
   output logic tx_clock_oe,
   input wire logic rx_clock_in,
   output logic rx_clock_out,
   output logic rx_clock_oe,
   input wire logic tx_fs_in,
   input wire logic rx_fs_in,
   input wire logic rx_data_in,
   output logic tx_data_out,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   // registers and decode
   logic [1:0] ctrl;
   logic [RATIO_W-1:0] ratio;
   logic [10:0] rx_cmr;
   logic [10:0] tx_cmr;
   logic [7:0] rx_fmr;
   logic [7:0] tx_fmr;
   logic [31:0] tx_hold;
   logic [31:0] rx_hold;
   logic hold_full;
   logic rx_avail;
   logic overrun;
   logic [STATUS_W-1:0] mask;
   wire wr_ctrl = wr && (addr == CTRL_OFS);
   wire wr_cmr = wr && (addr == CLOCK_MODE_OFS);
   wire wr_receive_clock_mode_reg = wr && (addr == RX_CLOCK_MODE_OFS);
   wire wr_rfmr = wr && (addr == RX_FRAME_OFS);
   wire wr_transmit_clock_mode_reg = wr && (addr == TX_CLOCK_MODE_OFS);
   wire wr_tfmr = wr && (addr == TX_FRAME_OFS);
   wire wr_thold = wr && (addr == TX_HOLD_OFS);
   wire wr_ier = wr && (addr == INT_ENABLE_OFS);
   wire wr_idr = wr && (addr == INT_DISABLE_OFS);
   wire rd_rhold = rd && (addr == RX_HOLD_OFS);
   wire rd_status = rd && (addr == STATUS_OFS);
   wire rx_en = ctrl[RX_EN_BIT];
   wire tx_en = ctrl[TX_EN_BIT];
   wire [1:0] tx_cks = tx_cmr[CKS_LSB +: 2];
   wire [1:0] rx_cks = rx_cmr[CKS_LSB +: 2];
   wire [1:0] tx_cko = tx_cmr[CKO_LSB +: 2];
   wire [1:0] rx_cko = rx_cmr[CKO_LSB +: 2];
   wire [2:0] tx_start = tx_cmr[START_LSB +: 3];
   wire [2:0] rx_start = rx_cmr[START_LSB +: 3];
   wire [4:0] tx_len = tx_fmr[DATLEN_LSB +: 5];
   wire [4:0] rx_len = rx_fmr[DATLEN_LSB +: 5];
   wire tx_msbf = tx_fmr[MSBF_BIT];
   wire rx_msbf = rx_fmr[MSBF_BIT];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= 2'h0;
         ratio <= 12'h000;
         rx_cmr <= 11'h000;
         tx_cmr <= 11'h000;
         rx_fmr <= 8'h00;
         tx_fmr <= 8'h00;
         tx_hold <= REG_RESET;
      end else begin
         if (wr_ctrl) ctrl <= wdata[1:0];
         if (wr_cmr) ratio <= wdata[RATIO_W-1:0];
         if (wr_receive_clock_mode_reg) rx_cmr <= wdata[10:0];
         if (wr_transmit_clock_mode_reg) tx_cmr <= wdata[10:0];
         if (wr_rfmr) rx_fmr <= wdata[7:0];
         if (wr_tfmr) tx_fmr <= wdata[7:0];
         if (wr_thold) tx_hold <= wdata;
      end
   end
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 5'h00;
         pin_sync <= 5'h00;
      end else begin
         pin_meta <= {rx_data_in, rx_fs_in, tx_fs_in, rx_clock_in, tx_clock_in};
         pin_sync <= pin_meta;
      end
   end
   wire tx_pin = pin_sync[0];
   wire rx_pin = pin_sync[1];
   wire tx_fs = pin_sync[2];
   wire rx_fs = pin_sync[3];
   wire rx_bit = pin_sync[4];
   ////////////////////////////////////////////////////////////////////
   // common divider
   logic [RATIO_W-1:0] div_cnt;
   logic div_clk;
   wire div_last = (div_cnt >= ratio - 12'h001);
   // half period of ratio cycles, stopped at zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= 12'h000;
         div_clk <= 1'b0;
      end else if (ratio == 12'h000) begin
         div_cnt <= 12'h000;
         div_clk <= 1'b0;
      end else if (div_last) begin
         div_cnt <= 12'h000;
         div_clk <= ~div_clk;
      end else begin
         div_cnt <= div_cnt + 12'h001;
      end
   end
   // other side means the far pin or divider, never its cross choice: no loop
   wire tx_own = (tx_cks == CKS_PIN) ? tx_pin : div_clk;
   wire rx_own = (rx_cks == CKS_PIN) ? rx_pin : div_clk;
   wire tx_raw = (tx_cks == CKS_OTHER) ? rx_own : tx_own;
   wire rx_raw = (rx_cks == CKS_OTHER) ? tx_own : rx_own;
   wire tx_lvl = tx_raw ^ tx_cmr[CKI_BIT];
   wire rx_lvl = rx_raw ^ rx_cmr[CKI_BIT];
   logic tx_prev;
   logic rx_prev;
   // transmit drives on falling, receive samples on rising internal edge
   wire tx_edge = tx_prev & ~tx_lvl;
   wire rx_edge = ~rx_prev & rx_lvl;
   path_state_t tx_state;
   path_state_t rx_state;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_prev <= 1'b0;
         rx_prev <= 1'b0;
         tx_clock_out <= 1'b0;
         rx_clock_out <= 1'b0;
         tx_clock_oe <= 1'b0;
         rx_clock_oe <= 1'b0;
      end else begin
         tx_prev <= tx_lvl;
         rx_prev <= rx_lvl;
         tx_clock_out <= tx_raw;
         rx_clock_out <= rx_raw;
         tx_clock_oe <= (tx_cko == CKO_CONT) || ((tx_cko == CKO_XFER) && (tx_state == SHIFT));
         rx_clock_oe <= (rx_cko == CKO_CONT) || ((rx_cko == CKO_XFER) && (rx_state == SHIFT));
      end
   end
   ////////////////////////////////////////////////////////////////////
   // start events
   function automatic logic start_hit(input logic [2:0] mode, input logic fs, input logic fsp,
                                      input logic cont_ok, input logic other);
      case (mode)
         START_CONT: start_hit = cont_ok;
         START_OTHER: start_hit = other;
         START_LOW: start_hit = ~fs;
         START_HIGH: start_hit = fs;
         START_FALL: start_hit = fsp & ~fs;
         START_RISE: start_hit = ~fsp & fs;
         START_ANY: start_hit = fs ^ fsp;
         default: start_hit = 1'b0;
      endcase
   endfunction
   logic tx_fsp;
   logic rx_fsp;
   logic tx_begun;
   logic rx_begun;
   logic tx_other_pend;
   logic rx_other_pend;
   wire tx_go = start_hit(tx_start, tx_fs, tx_fsp, 1'b1, tx_other_pend);
   wire rx_go = start_hit(rx_start, rx_fs, rx_fsp, rx_en, rx_other_pend);
   // lockstep: far side's frame start held until own edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_other_pend <= 1'b0;
         rx_other_pend <= 1'b0;
      end else begin
         tx_other_pend <= rx_begun | (tx_other_pend & ~tx_edge);
         rx_other_pend <= tx_begun | (rx_other_pend & ~rx_edge);
      end
   end
   logic [31:0] tx_sh;
   logic [4:0] tx_cnt;
   logic tx_take;
   wire tx_last = (tx_cnt == tx_len);
   wire [4:0] tx_next_cnt = tx_cnt + 5'h01;
   wire [4:0] tx_idx = tx_msbf ? (tx_len - tx_next_cnt) : tx_next_cnt;
   wire [4:0] tx_first = tx_msbf ? tx_len : 5'h00;
   wire tx_load_idle = (tx_state == IDLE) && tx_en && hold_full && tx_go;
   wire tx_load_next = (tx_state == SHIFT) && tx_last && tx_en && hold_full
                       && (tx_start == START_CONT);
   wire tx_load = tx_edge && (tx_load_idle || tx_load_next);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_state <= IDLE;
         tx_sh <= REG_RESET;
         tx_cnt <= 5'h00;
         tx_data_out <= 1'b0;
         tx_fsp <= 1'b0;
         tx_take <= 1'b0;
         tx_begun <= 1'b0;
      end else begin
         tx_take <= tx_load;
         tx_begun <= tx_edge && tx_load_idle;
         if (tx_edge) begin
            tx_fsp <= tx_fs;
            if (tx_load) begin
               tx_sh <= tx_hold;
               tx_cnt <= 5'h00;
               tx_data_out <= tx_hold[tx_first];
               tx_state <= SHIFT;
            end else begin
               case (tx_state)
                  IDLE: tx_data_out <= 1'b0;
                  SHIFT: begin
                     if (tx_last) begin
                        tx_state <= IDLE;
                        tx_data_out <= 1'b0;
                     end else begin
                        tx_cnt <= tx_next_cnt;
                        tx_data_out <= tx_sh[tx_idx];
                     end
                  end
                  default: tx_state <= IDLE;
               endcase
            end
         end
      end
   end
   // a write landing with the transfer wins: the new word stays pending
   // holding freed when shifter takes it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_full <= 1'b0;
      end else begin
         hold_full <= wr_thold | (hold_full & ~tx_take);
      end
   end
   ////////////////////////////////////////////////////////////////////
   // receive path
   logic [31:0] rx_sh;
   logic [4:0] rx_cnt;
   logic rx_done;
   wire rx_last = (rx_cnt == rx_len);
   wire [31:0] rx_msb_word = {rx_sh[30:0], rx_bit};
   wire [31:0] rx_lsb_word = rx_sh | ({31'h0, rx_bit} << rx_cnt);
   wire [31:0] rx_word = rx_msbf ? rx_msb_word : rx_lsb_word;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_state <= IDLE;
         rx_sh <= REG_RESET;
         rx_cnt <= 5'h00;
         rx_hold <= REG_RESET;
         rx_fsp <= 1'b0;
         rx_done <= 1'b0;
         rx_begun <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         rx_begun <= 1'b0;
         if (rx_edge) begin
            rx_fsp <= rx_fs;
            case (rx_state)
               IDLE: begin
                  if (rx_go) begin
                     rx_state <= SHIFT;
                     rx_cnt <= 5'h00;
                     rx_sh <= REG_RESET;
                     rx_begun <= 1'b1;
                  end
               end
               SHIFT: begin
                  if (rx_last) begin
                     rx_hold <= rx_word;
                     rx_done <= 1'b1;
                     rx_cnt <= 5'h00;
                     rx_sh <= REG_RESET;
                     if (!(rx_en && (rx_start == START_CONT))) rx_state <= IDLE;
                  end else begin
                     rx_sh <= rx_word;
                     rx_cnt <= rx_cnt + 5'h01;
                  end
               end
               default: rx_state <= IDLE;
            endcase
         end
      end
   end
   // arrival wins over a clearing read in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_avail <= 1'b0;
         overrun <= 1'b0;
      end else begin
         rx_avail <= rx_done | (rx_avail & ~rd_rhold);
         overrun <= (rx_done & rx_avail & ~rd_rhold) | (overrun & ~rd_status);
      end
   end
   wire tx_free = ~hold_full;
   wire tx_drained = ~hold_full && (tx_state == IDLE) && ~tx_take;
   wire [STATUS_W-1:0] status = {overrun, rx_avail, 2'h0, tx_drained, tx_free};
   // set and clear mask by one-bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask <= 6'h00;
         irq <= 1'b0;
      end else begin
         mask <= (mask | (wr_ier ? wdata[STATUS_W-1:0] : 6'h00))
                 & ~(wr_idr ? wdata[STATUS_W-1:0] : 6'h00);
         irq <= |(status & mask);
      end
   end
   wire [31:0] read_mux =
      (addr == CTRL_OFS) ? {30'h0, ctrl} :
      (addr == CLOCK_MODE_OFS) ? {20'h0, ratio} :
      (addr == RX_CLOCK_MODE_OFS) ? {21'h0, rx_cmr} :
      (addr == RX_FRAME_OFS) ? {24'h0, rx_fmr} :
      (addr == TX_CLOCK_MODE_OFS) ? {21'h0, tx_cmr} :
      (addr == TX_FRAME_OFS) ? {24'h0, tx_fmr} :
      (addr == RX_HOLD_OFS) ? rx_hold :
      (addr == TX_HOLD_OFS) ? tx_hold :
      (addr == STATUS_OFS) ? {26'h0, status} :
      (addr == INT_MASK_OFS) ? {26'h0, mask} : 32'h0;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= REG_RESET;
      end else begin
         rdata <= rd ? read_mux : 32'h0;
      end
   end
endmodule

// ### sync_serial_unit_checker.sv
// port-level checker for the sync serial unit
`timescale 1ns/1ps
module sync_serial_unit_checker import sync_serial_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic tx_clock_in,
   input wire logic tx_clock_out,
   input wire logic tx_clock_oe,
   input wire logic rx_clock_in,
   input wire logic rx_clock_out,
   input wire logic rx_clock_oe,
   input wire logic tx_fs_in,
   input wire logic rx_fs_in,
   input wire logic rx_data_in,
   input wire logic tx_data_out,
   input wire logic irq
);
////////////////////////////////////////////////////////////////////////
// shadow of the configuration seen on the bus
logic [11:0] ratio;
logic [3:0] txm;
logic [3:0] rxm;
logic [5:0] mask;
logic [12:0] quiet;
logic [12:0] run;
logic prev_tx;
wire cfg_wr = wr && (addr == CLOCK_MODE_OFS || addr == TX_CLOCK_MODE_OFS
   || addr == RX_CLOCK_MODE_OFS);
wire tx_div = txm[1];
// quiet counts cycles since the last clock setup write, so old settings age out
always_ff @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ratio <= '0;
      txm <= '0;
      rxm <= '0;
      mask <= '0;
      quiet <= '0;
      run <= '0;
      prev_tx <= 1'b0;
   end else begin
      if (wr && addr == CLOCK_MODE_OFS) ratio <= wdata[11:0];
      if (wr && addr == TX_CLOCK_MODE_OFS) txm <= wdata[3:0];
      if (wr && addr == RX_CLOCK_MODE_OFS) rxm <= wdata[3:0];
      if (wr && addr == INT_ENABLE_OFS) mask <= mask | wdata[5:0];
      if (wr && addr == INT_DISABLE_OFS) mask <= mask & ~wdata[5:0];
      quiet <= cfg_wr ? '0 : (&quiet ? quiet : quiet + 13'h1);
      run <= (tx_clock_out != prev_tx) ? 13'h1 : (&run ? run : run + 13'h1);
      prev_tx <= tx_clock_out;
   end
end
////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
a_phase_len: assert property (
   tx_clock_out != prev_tx && tx_div && ratio != 12'h0
   && {1'b0, quiet} > {run, 1'b0} + 14'h4 |-> run == {1'b0, ratio})
   else $error("divided clock phase length wrong");
a_div_stopped: assert property (
   tx_div && ratio == 12'h0 && quiet > 13'h8 |-> $stable(tx_clock_out))
   else $error("divided clock moves with ratio zero");
a_tx_pad_cont: assert property (
   txm[3:2] == CKO_CONT && quiet > 13'h3 |-> tx_clock_oe)
   else $error("transmit pad not driven in continuous mode");
a_tx_pad_off: assert property (
   txm[3:2] == CKO_NONE && quiet > 13'h3 |-> !tx_clock_oe)
   else $error("transmit pad driven while output off");
a_rx_pad_cont: assert property (
   rxm[3:2] == CKO_CONT && quiet > 13'h3 |-> rx_clock_oe)
   else $error("receive pad not driven in continuous mode");
a_rx_pad_off: assert property (
   rxm[3:2] == CKO_NONE && quiet > 13'h3 |-> !rx_clock_oe)
   else $error("receive pad driven while output off");
a_rx_follows_tx: assert property (
   rxm[1:0] == CKS_OTHER && tx_div && quiet > 13'h4 |-> rx_clock_out == tx_clock_out)
   else $error("receive clock does not follow transmit clock");
a_irq_disable: assert property (
   wr && addr == INT_DISABLE_OFS && wdata[5:0] == 6'h3f
   ##1 !(wr && addr == INT_ENABLE_OFS) |-> ##1 !irq)
   else $error("interrupt stays up after full disable");
a_irq_masked: assert property (
   mask == 6'h0 && $past(mask) == 6'h0 |-> !irq)
   else $error("interrupt raised with every source masked");
c_irq_rise: cover property ($rose(irq));
c_tx_frame: cover property ($rose(tx_clock_oe) ##[1:200] tx_data_out);
c_rx_pad: cover property (rx_clock_oe);
endmodule

bind sync_serial_unit sync_serial_unit_checker sync_serial_unit_checker_inst (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .tx_clock_in(tx_clock_in), .tx_clock_out(tx_clock_out),
   .tx_clock_oe(tx_clock_oe), .rx_clock_in(rx_clock_in), .rx_clock_out(rx_clock_out),
   .rx_clock_oe(rx_clock_oe), .tx_fs_in(tx_fs_in), .rx_fs_in(rx_fs_in),
   .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .irq(irq));

// ### serial_codec_model.sv
// far-side codec model: receive clock, frame sync and data
`timescale 1ns/1ps
module serial_codec_model #(parameter int HALF = 8) (
   input wire logic clk,
   output logic rx_clock,
   output logic rx_fs,
   output logic rx_data,
   output logic tx_clock,
   output logic tx_fs
);
// pad clocks stand still, at most clk/16 in frames
initial begin
   rx_clock = 1'b0;
   rx_fs = 1'b0;
   rx_data = 1'b0;
   tx_clock = 1'b0;
   tx_fs = 1'b0;
end
task automatic half_cycle(input logic lvl);
   repeat (HALF) @(posedge clk);
   rx_clock <= lvl;
endtask
// frame sync high at the start edge, bits msb first
task automatic send_word(input logic [7:0] w);
   int i;
   @(posedge clk);
   rx_fs <= 1'b1;
   half_cycle(1'b1);
   for (i = 7; i >= 0; i--) begin
      half_cycle(1'b0);
      rx_fs <= 1'b0;
      rx_data <= w[i];
      half_cycle(1'b1);
   end
   half_cycle(1'b0);
   // released line must not keep the last bit
   rx_data <= ~w[0];
endtask
endmodule

// ### test_sync_serial_clock_and_shifters.sv
// self-checking bench for the sync serial clocking and shift core
`timescale 1ns/1ps
module test_sync_serial_clock_and_shifters import sync_serial_pkg::*; ;
logic clk = 1'b0;
logic rstn = 1'b0;
logic wr = 1'b0;
logic rd = 1'b0;
logic [7:0] addr = 8'h00;
logic [31:0] wdata = 32'h0;
logic [31:0] rdata, got, k;
logic tx_clock_in, tx_fs_in, rx_clock_in, rx_fs_in, rx_data_in;
logic tx_clock_out, tx_clock_oe, rx_clock_out, rx_clock_oe, tx_data_out, irq;
int n_fail = 0;
int cmp_count = 0;
int i, j;
always #5 clk = ~clk;
sync_serial_unit sync_serial_unit_inst (.clk(clk), .rstn(rstn), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_clock_in(tx_clock_in),
   .tx_clock_out(tx_clock_out), .tx_clock_oe(tx_clock_oe), .rx_clock_in(rx_clock_in),
   .rx_clock_out(rx_clock_out), .rx_clock_oe(rx_clock_oe), .tx_fs_in(tx_fs_in),
   .rx_fs_in(rx_fs_in), .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .irq(irq));
serial_codec_model serial_codec_model_inst (.clk(clk), .rx_clock(rx_clock_in),
   .rx_fs(rx_fs_in), .rx_data(rx_data_in), .tx_clock(tx_clock_in), .tx_fs(tx_fs_in));
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] g, input logic [31:0] e);
   cmp_count++;
   if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
   end
endtask
task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
   @(posedge clk);
   wr <= 1'b1;
   addr <= a;
   wdata <= d;
   @(posedge clk);
   wr <= 1'b0;
endtask
task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
   @(posedge clk);
   rd <= 1'b1;
   addr <= a;
   @(posedge clk);
   rd <= 1'b0;
   #1;
   check(rdata, e);
endtask
// measures one full phase of the pad clock, capped at 200 cycles
task automatic phase_len(input logic [31:0] e);
   logic v;
   logic [31:0] n;
   int c;
   n = '0;
   @(posedge clk);
   v = tx_clock_out;
   for (c = 0; c < 200 && tx_clock_out === v; c++) @(posedge clk);
   v = tx_clock_out;
   for (c = 0; c < 200 && tx_clock_out === v; c++) begin
      @(posedge clk);
      n++;
   end
   check(n, e);
endtask
task give_verdict;
   $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
   if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
   end else begin
      $display("Testbench failed");
   end
   $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
   repeat (40000) @(posedge clk);
   n_fail++;
   give_verdict;
end
initial begin
   repeat (8) @(posedge clk);
   rstn <= 1'b1;
   // pin source is never paired with continuous output
   wr_reg(RX_CLOCK_MODE_OFS, 32'h25);
   for (i = 1; i < 6; i += 2) begin
      wr_reg(TX_CLOCK_MODE_OFS, (i == 5) ? 32'h26 : 32'h6);
      wr_reg(CLOCK_MODE_OFS, 32'(i));
      repeat (12) @(posedge clk);
      phase_len(32'(i));
      k = '0;
      for (j = 0; j < 20; j++) begin
         @(posedge clk);
         if (rx_clock_out !== tx_clock_out) k++;
      end
      check(k, 32'h0);
   end
   wr_reg(CLOCK_MODE_OFS, 32'hffff_ffff);
   rd_reg(CLOCK_MODE_OFS, 32'hfff);
   wr_reg(CLOCK_MODE_OFS, 32'h0);
   phase_len(32'd200);
   $display("test divider done");
   wr_reg(RX_CLOCK_MODE_OFS, 32'h300);
   wr_reg(RX_FRAME_OFS, 32'h87);
   wr_reg(TX_CLOCK_MODE_OFS, 32'ha);
   wr_reg(TX_FRAME_OFS, 32'h87);
   wr_reg(CLOCK_MODE_OFS, 32'h6);
   wr_reg(CTRL_OFS, 32'h3);
   rd_reg(STATUS_OFS, 32'h3);
   wr_reg(TX_HOLD_OFS, 32'hb5);
   fork
      begin
         got = '0;
         wait (tx_data_out === 1'b1);
         for (j = 0; j < 16; j++) begin
            @(posedge tx_clock_out);
            got = {got[30:0], tx_data_out};
         end
         check(got, 32'hb53c);
         check({31'h0, tx_clock_oe}, 32'h1);
      end
      begin
         wait (tx_data_out === 1'b1);
         repeat (3) @(posedge clk);
         rd_reg(STATUS_OFS, 32'h1);
         wr_reg(TX_HOLD_OFS, 32'h3c);
      end
   join
   repeat (30) @(posedge clk);
   check({30'h0, tx_clock_oe, tx_data_out}, 32'h0);
   rd_reg(STATUS_OFS, 32'h3);
   $display("test transmit done");
   serial_codec_model_inst.send_word(8'h5a);
   repeat (10) @(posedge clk);
   rd_reg(STATUS_OFS, 32'h13);
   serial_codec_model_inst.send_word(8'hc3);
   repeat (10) @(posedge clk);
   rd_reg(STATUS_OFS, 32'h33);
   rd_reg(RX_HOLD_OFS, 32'hc3);
   rd_reg(STATUS_OFS, 32'h3);
   $display("test receive done");
   wr_reg(RX_CLOCK_MODE_OFS, 32'h101);
   wr_reg(TX_CLOCK_MODE_OFS, 32'h2);
   wr_reg(TX_HOLD_OFS, 32'h5a);
   repeat (150) @(posedge clk);
   rd_reg(STATUS_OFS, 32'h13);
   rd_reg(RX_HOLD_OFS, 32'h0);
   $display("test lockstep done");
   wr_reg(TX_CLOCK_MODE_OFS, 32'h2);
   wr_reg(INT_ENABLE_OFS, 32'h1);
   repeat (3) @(posedge clk);
   check({31'h0, irq}, 32'h1);
   rd_reg(INT_MASK_OFS, 32'h1);
   wr_reg(INT_DISABLE_OFS, 32'h3f);
   repeat (3) @(posedge clk);
   check({31'h0, irq}, 32'h0);
   rd_reg(INT_MASK_OFS, 32'h0);
   wr_reg(8'h7c, 32'hffff_ffff);
   rd_reg(8'h7c, 32'h0);
   $display("test interrupt done");
   give_verdict;
end
endmodule
